// >>> common/tbl_alu_defines.svh
// Constants for the table read, bit move and add/sub datapath
`ifndef TBL_ALU_DEFINES_SVH
`define TBL_ALU_DEFINES_SVH

// ----------------------------------------------------------------
// Register pair indices (any_pair encoding)
// ----------------------------------------------------------------
`define PAIR_ACC 3'h0
`define PAIR_MEM 3'h1
`define PAIR_TBL 3'h2
`define PAIR_UPR 3'h3

// ----------------------------------------------------------------
// Nibble positions in the register file
// ----------------------------------------------------------------
`define NIB_A 4'h1
`define NIB_H 4'h2
`define NIB_L 4'h3
`define NIB_C 4'h7

// ----------------------------------------------------------------
// Program memory address fields
// ----------------------------------------------------------------
`define PAGE_MSB 10
`define PAGE_LSB 8
`define ADDR_STEP 11'h001

// ----------------------------------------------------------------
// Data memory address fields for bit addressing
// ----------------------------------------------------------------
`define FMEM_HI 4'hf
`define FMEM_LO0 4'hb
`define FMEM_LO1 4'hf
`define PMEM_TOP 6'h3f
`define HMEM_BANK 4'h0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define REG_RESET 4'h0
`define CARRY_RESET 1'b0

`endif

// >>> common/tbl_alu_pkg.sv
// Types for the table read, bit move and add/sub datapath
package tbl_alu_pkg;

	// ----------------------------------------------------------------
	// Operations issued by the sequencer
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		OP_TBL_PCDE = 5'h00,
		OP_TBL_PCXA = 5'h01,
		OP_TBL_BCDE = 5'h02,
		OP_TBL_BCXA = 5'h03,
		OP_BIT_LOAD = 5'h04,
		OP_BIT_STORE = 5'h05,
		OP_ADDS_A_IMM = 5'h06,
		OP_ADDS_W_IMM = 5'h07,
		OP_ADDS_A_MEM = 5'h08,
		OP_ADDS_W_RP = 5'h09,
		OP_ADDS_RP_W = 5'h0a,
		OP_ADDCY_A_MEM = 5'h0b,
		OP_ADDCY_W_RP = 5'h0c,
		OP_ADDCY_RP_W = 5'h0d,
		OP_SUBSK_A_MEM = 5'h0e,
		OP_SUBSK_W_RP = 5'h0f,
		OP_SUBSK_RP_W = 5'h10,
		OP_SUBCY_A_MEM = 5'h11,
		OP_SUBCY_W_RP = 5'h12,
		OP_SUBCY_RP_W = 5'h13
	} op_t;

	// ----------------------------------------------------------------
	// Bit manipulation addressing modes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		BIT_FMEM = 2'h0,
		BIT_PMEM_L = 2'h1,
		BIT_H_MEM = 2'h2
	} bit_mode_t;

	// ----------------------------------------------------------------
	// Sequencing states, Gray coded along idle-read-calc-write
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_READ = 2'h1,
		ST_CALC = 2'h3,
		ST_WRITE = 2'h2
	} state_t;

endpackage : tbl_alu_pkg

// >>> common/arith_if.sv
// Operand and result bundle between the datapath and its adder
interface arith_if;
	logic [7:0] a;
	logic [7:0] b;
	logic cin;
	logic sub;
	logic wide;
	logic [7:0] res;
	logic cout;

	modport calc (
		input a,
		input b,
		input cin,
		input sub,
		input wide,
		output res,
		output cout
	);

	modport user (
		output a,
		output b,
		output cin,
		output sub,
		output wide,
		input res,
		input cout
	);
endinterface : arith_if

// >>> design/arith_unit.sv
// Four or eight bit adder/subtractor with carry or borrow out
module arith_unit (
	arith_if.calc ar
);
	logic [8:0] s8;
	logic [4:0] s4;

	// ----------------------------------------------------------------
	// Sum or difference; borrow appears as the top bit wrapping to one
	// ----------------------------------------------------------------
	assign s8 = ar.sub ? ({1'b0, ar.a} - {1'b0, ar.b} - {8'h00, ar.cin})
		: ({1'b0, ar.a} + {1'b0, ar.b} + {8'h00, ar.cin});
	assign s4 = ar.sub ?
		({1'b0, ar.a[3:0]} - {1'b0, ar.b[3:0]} - {4'h0, ar.cin})
		: ({1'b0, ar.a[3:0]} + {1'b0, ar.b[3:0]} + {4'h0, ar.cin});

	assign ar.res = ar.wide ? s8[7:0] : {4'h0, s4[3:0]};
	assign ar.cout = ar.wide ? s8[8] : s4[4];
endmodule : arith_unit

// >>> design/table_read_bit_move_add_sub_unit.sv
// Table read, bit move and add/sub execution datapath of a 4-bit core
`include "tbl_alu_defines.svh"

// Notes on behaviour
// - page-relative read via table_ptr_pair; low nibble to A, high to X
// - table reads leave prog_counter alone; low byte replaced for fetch only
// - a read at the last page address takes the following page
// - page-relative read via wide_acc; low nibble to A, high to X
// - absolute read from upper_ptr_pair and table_ptr_pair nibbles
// - absolute read from upper_ptr_pair and wide_acc; byte into wide_acc
// - bit_move load copies one addressed memory bit into carry_flag
// - bit_move store writes carry_flag into one bit, other bits kept
// - add 4-bit immediate to A; skip on carry; carry_flag untouched
// - add 8-bit immediate to wide_acc; skip on carry out of bit 7
// - skip adds with memory or pair operand write the sum, carry kept
// - any_pair picks one of eight pairs; destination form excludes wide_acc
// - add_with_carry of memory into A sets or clears carry_flag
// - 4-bit immediate add after memory add_with_carry is dropped or runs without skip
// - pair add_with_carry in either direction sets carry from bit 7
// - sub_skip_on_borrow stores difference, skips on borrow, keeps carry
// - sub_with_borrow of memory from A sets carry_flag on borrow
module table_read_bit_move_add_sub_unit (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic exec_valid,
	output logic exec_ready,
	input wire tbl_alu_pkg::op_t exec_op,
	input wire logic [7:0] exec_imm,
	input wire logic [2:0] exec_pair,
	input wire tbl_alu_pkg::bit_mode_t exec_bit_mode,
	input wire logic [1:0] exec_bit_sel,
	input wire logic [10:0] exec_prog_counter,
	input wire logic other_instr,
	output logic exec_done,
	output logic skip_req,
	output logic rom_rd,
	output logic [10:0] rom_addr,
	input wire logic [7:0] rom_rdata,
	output logic dmem_rd,
	output logic dmem_wr,
	output logic [11:0] dmem_addr,
	output logic [3:0] dmem_wdata,
	input wire logic [3:0] dmem_rdata,
	output logic carry_flag,
	output logic [7:0] wide_acc
);
	import tbl_alu_pkg::*;

	// ----------------------------------------------------------------
	// Operation decoding
	// ----------------------------------------------------------------
	function automatic logic is_table(input op_t op);
		is_table = (op == OP_TBL_PCDE) || (op == OP_TBL_PCXA)
			|| (op == OP_TBL_BCDE) || (op == OP_TBL_BCXA);
	endfunction : is_table

	function automatic logic is_bit(input op_t op);
		is_bit = (op == OP_BIT_LOAD) || (op == OP_BIT_STORE);
	endfunction : is_bit

	function automatic logic is_acc_mem(input op_t op);
		is_acc_mem = (op == OP_ADDS_A_MEM) || (op == OP_ADDCY_A_MEM)
			|| (op == OP_SUBSK_A_MEM) || (op == OP_SUBCY_A_MEM);
	endfunction : is_acc_mem

	function automatic logic is_w_rp(input op_t op);
		is_w_rp = (op == OP_ADDS_W_RP) || (op == OP_ADDCY_W_RP)
			|| (op == OP_SUBSK_W_RP) || (op == OP_SUBCY_W_RP);
	endfunction : is_w_rp

	function automatic logic is_rp_w(input op_t op);
		is_rp_w = (op == OP_ADDS_RP_W) || (op == OP_ADDCY_RP_W)
			|| (op == OP_SUBSK_RP_W) || (op == OP_SUBCY_RP_W);
	endfunction : is_rp_w

	function automatic logic is_sub(input op_t op);
		is_sub = (op == OP_SUBSK_A_MEM) || (op == OP_SUBSK_W_RP)
			|| (op == OP_SUBSK_RP_W) || (op == OP_SUBCY_A_MEM)
			|| (op == OP_SUBCY_W_RP) || (op == OP_SUBCY_RP_W);
	endfunction : is_sub

	function automatic logic uses_carry(input op_t op);
		uses_carry = (op == OP_ADDCY_A_MEM) || (op == OP_ADDCY_W_RP)
			|| (op == OP_ADDCY_RP_W) || (op == OP_SUBCY_A_MEM)
			|| (op == OP_SUBCY_W_RP) || (op == OP_SUBCY_RP_W);
	endfunction : uses_carry

	function automatic logic is_arith(input op_t op);
		is_arith = !is_table(op) && !is_bit(op);
	endfunction : is_arith

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	state_t state_q;
	state_t state_d;
	op_t op_q;
	logic [7:0] imm_q;
	logic [2:0] pair_q;
	logic [1:0] bit_q;
	logic [10:0] rom_addr_q;
	logic [11:0] dmem_addr_q;
	logic [3:0] wdata_q;
	logic carry_q;
	logic adj_q;
	logic adj_sub_q;
	logic done_q;
	logic skip_q;
	logic [3:0] regs_q [16];
	logic [7:0] pair_v [8];

	// ----------------------------------------------------------------
	// Register pair views, index 2p high nibble, 2p+1 low nibble
	// ----------------------------------------------------------------
	genvar gp;
	generate
		for (gp = 0; gp < 8; gp++) begin : g_pair
			assign pair_v[gp] = {regs_q[2 * gp], regs_q[2 * gp + 1]};
		end
	endgenerate

	// ----------------------------------------------------------------
	// Address formation at issue
	// ----------------------------------------------------------------
	wire accept = exec_valid && exec_ready;
	wire [10:0] addr_next = exec_prog_counter + `ADDR_STEP;
	wire [2:0] next_pg = addr_next[`PAGE_MSB:`PAGE_LSB];
	wire [2:0] up_page = regs_q[`NIB_C][2:0];
	wire [3:0] reg_h = regs_q[`NIB_H];
	wire [3:0] reg_l = regs_q[`NIB_L];
	wire [10:0] rom_addr_d =
		(exec_op == OP_TBL_PCDE) ? {next_pg, pair_v[`PAIR_TBL]} :
		(exec_op == OP_TBL_PCXA) ? {next_pg, pair_v[`PAIR_ACC]} :
		(exec_op == OP_TBL_BCDE) ? {up_page, pair_v[`PAIR_TBL]} :
		{up_page, pair_v[`PAIR_ACC]};
	wire [3:0] fmem_lo = exec_imm[4] ? `FMEM_LO1 : `FMEM_LO0;
	wire [11:0] bit_addr =
		(exec_bit_mode == BIT_FMEM) ? {`FMEM_HI, fmem_lo, exec_imm[3:0]} :
		(exec_bit_mode == BIT_PMEM_L) ?
		{`PMEM_TOP, exec_imm[3:0], reg_l[3:2]} :
		{`HMEM_BANK, reg_h, exec_imm[3:0]};
	wire [1:0] bit_sel_d = (exec_bit_mode == BIT_PMEM_L) ? reg_l[1:0]
		: exec_bit_sel;
	wire [11:0] dmem_addr_d = is_bit(exec_op) ? bit_addr
		: {`HMEM_BANK, reg_h, reg_l};
	wire needs_read = is_table(exec_op) || is_bit(exec_op)
		|| is_acc_mem(exec_op);

	// ----------------------------------------------------------------
	// Arithmetic operands
	// ----------------------------------------------------------------
	arith_if ar ();
	arith_unit u_arith (
		.ar(ar)
	);

	wire wide_op = is_w_rp(op_q) || is_rp_w(op_q)
		|| (op_q == OP_ADDS_W_IMM);
	assign ar.a = is_rp_w(op_q) ? pair_v[pair_q]
		: wide_op ? pair_v[`PAIR_ACC] : {4'h0, regs_q[`NIB_A]};
	assign ar.b = is_acc_mem(op_q) ? {4'h0, dmem_rdata} :
		(op_q == OP_ADDS_A_IMM) ? {4'h0, imm_q[3:0]} :
		(op_q == OP_ADDS_W_IMM) ? imm_q :
		is_w_rp(op_q) ? pair_v[pair_q] : pair_v[`PAIR_ACC];
	assign ar.cin = uses_carry(op_q) && carry_q;
	assign ar.sub = is_sub(op_q);
	assign ar.wide = wide_op;

	// ----------------------------------------------------------------
	// Result control
	// ----------------------------------------------------------------
	wire in_calc = (state_q == ST_CALC);
	wire legal = !(is_rp_w(op_q) && (pair_q == `PAIR_ACC));
	wire adj_hit = adj_q && (op_q == OP_ADDS_A_IMM);
	wire adj_kill = adj_hit && (adj_sub_q ? !carry_q : carry_q);
	wire arith_ok = in_calc && is_arith(op_q) && legal && !adj_kill;
	wire skip_d = arith_ok && !uses_carry(op_q) && ar.cout
		&& !adj_hit;
	wire finish = (in_calc && (op_q != OP_BIT_STORE))
		|| (state_q == ST_WRITE);
	wire wr_en = (in_calc && is_table(op_q)) || arith_ok;
	wire [2:0] wr_pair = is_rp_w(op_q) ? pair_q : `PAIR_ACC;
	wire wr_hi = is_table(op_q) || wide_op;
	wire [7:0] wr_val = is_table(op_q) ? rom_rdata : ar.res;
	wire [3:0] bit_mask = 4'h1 << bit_q;
	wire [3:0] store_val = (dmem_rdata & ~bit_mask)
		| (carry_q ? bit_mask : 4'h0);

	// ----------------------------------------------------------------
	// Sequencing
	// ----------------------------------------------------------------
	always_comb begin
		case (state_q)
			ST_IDLE: state_d = accept ? (needs_read ? ST_READ : ST_CALC)
				: ST_IDLE;
			ST_READ: state_d = ST_CALC;
			ST_CALC: state_d = (op_q == OP_BIT_STORE) ? ST_WRITE : ST_IDLE;
			ST_WRITE: state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			op_q <= OP_TBL_PCDE;
			imm_q <= 8'h00;
			pair_q <= 3'h0;
			bit_q <= 2'h0;
			rom_addr_q <= 11'h000;
			dmem_addr_q <= 12'h000;
		end else if (accept) begin
			op_q <= exec_op;
			imm_q <= exec_imm;
			pair_q <= exec_pair;
			bit_q <= bit_sel_d;
			rom_addr_q <= rom_addr_d;
			dmem_addr_q <= dmem_addr_d;
		end
	end

	// ----------------------------------------------------------------
	// Carry flag and bit store data
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			carry_q <= `CARRY_RESET;
		end else if (in_calc && (op_q == OP_BIT_LOAD)) begin
			carry_q <= dmem_rdata[bit_q];
		end else if (arith_ok && uses_carry(op_q)) begin
			carry_q <= ar.cout;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wdata_q <= 4'h0;
		end else if (in_calc && (op_q == OP_BIT_STORE)) begin
			wdata_q <= store_val;
		end
	end

	// ----------------------------------------------------------------
	// Decimal adjustment tracking
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			adj_q <= 1'b0;
			adj_sub_q <= 1'b0;
		end else if (other_instr) begin
			adj_q <= 1'b0;
		end else if (finish) begin
			adj_q <= (op_q == OP_ADDCY_A_MEM)
				|| (op_q == OP_SUBCY_A_MEM);
			adj_sub_q <= (op_q == OP_SUBCY_A_MEM);
		end
	end

	// ----------------------------------------------------------------
	// Completion and skip request
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			done_q <= 1'b0;
			skip_q <= 1'b0;
		end else begin
			done_q <= finish;
			skip_q <= skip_d;
		end
	end

	// ----------------------------------------------------------------
	// Register file, one nibble per loop pass
	// ----------------------------------------------------------------
	genvar gn;
	generate
		for (gn = 0; gn < 16; gn++) begin : g_nib
			localparam logic [3:0] IDX = 4'(gn);
			wire hit = wr_en && (wr_pair == IDX[3:1]) && (IDX[0] || wr_hi);
			always_ff @(posedge sys_clk) begin
				if (!rst_n) begin
					regs_q[gn] <= `REG_RESET;
				end else if (hit) begin
					regs_q[gn] <= IDX[0] ? wr_val[3:0] : wr_val[7:4];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign exec_ready = (state_q == ST_IDLE);
	assign exec_done = done_q;
	assign skip_req = skip_q;
	assign rom_rd = (state_q == ST_READ) && is_table(op_q);
	assign rom_addr = rom_addr_q;
	assign dmem_rd = (state_q == ST_READ) && !is_table(op_q);
	assign dmem_wr = (state_q == ST_WRITE);
	assign dmem_addr = dmem_addr_q;
	assign dmem_wdata = wdata_q;
	assign carry_flag = carry_q;
	assign wide_acc = pair_v[`PAIR_ACC];
endmodule : table_read_bit_move_add_sub_unit

// >>> verification/mem_model.sv
// Behavioural program memory and data memory facing the datapath
module mem_model (
	input wire logic sys_clk,
	input wire logic rom_rd,
	input wire logic [10:0] rom_addr,
	output logic [7:0] rom_rdata,
	input wire logic dmem_rd,
	input wire logic dmem_wr,
	input wire logic [11:0] dmem_addr,
	input wire logic [3:0] dmem_wdata,
	output logic [3:0] dmem_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] dmem [4096];
	// -----
	// Table contents depend on the page as well as the low byte
	// -----
	function automatic logic [7:0] rom_b(logic [10:0] a);
		return a[7:0] ^ {a[10:8], 5'h00};
	endfunction : rom_b
	initial begin
		rom_rdata = 8'h00;
		dmem_rdata = 4'h0;
	end
	// Data valid one cycle after a strobe, scrambled otherwise
	always @(posedge sys_clk) begin
		rom_rdata <= rom_rd ? rom_b(rom_addr) : ~rom_rdata;
		dmem_rdata <= dmem_rd ? dmem[dmem_addr] : ~dmem_rdata;
		if (dmem_wr) begin
			dmem[dmem_addr] <= dmem_wdata;
		end
	end
endmodule : mem_model

// >>> verification/tbl_alu_props.sv
// Concurrent checks on the datapath's ports
module tbl_alu_props (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic exec_valid,
	input wire logic exec_ready,
	input wire tbl_alu_pkg::op_t exec_op,
	input wire logic [10:0] exec_prog_counter,
	input wire logic exec_done,
	input wire logic skip_req,
	input wire logic rom_rd,
	input wire logic [10:0] rom_addr,
	input wire logic dmem_rd,
	input wire logic dmem_wr,
	input wire logic carry_flag
);
	import tbl_alu_pkg::*;
	op_t op_q;
	logic [10:0] pcn_q;
	wire logic acc = exec_valid && exec_ready;
	wire logic tbl_now = exec_op <= OP_TBL_BCXA;
	wire logic pcrel_now = exec_op <= OP_TBL_PCXA;
	wire logic s_now = exec_op inside {[OP_ADDS_A_IMM:OP_ADDS_RP_W],
		[OP_SUBSK_A_MEM:OP_SUBSK_RP_W]};
	wire logic s_q = op_q inside {[OP_ADDS_A_IMM:OP_ADDS_RP_W],
		[OP_SUBSK_A_MEM:OP_SUBSK_RP_W]};
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// -----
	// Operation in flight and page of the next address
	// -----
	always_ff @(posedge sys_clk) begin
		pcn_q <= exec_prog_counter + 11'h001;
		if (!rst_n) begin
			op_q <= OP_TBL_PCDE;
		end else if (acc) begin
			op_q <= exec_op;
		end
	end
	property p_tbl_rom;
		acc && tbl_now |=> rom_rd;
	endproperty
	a_tbl_rom: assert property (p_tbl_rom)
		else $error("table read without ROM strobe");
	property p_tbl_page;
		acc && pcrel_now |=> rom_addr[10:8] == pcn_q[10:8];
	endproperty
	a_tbl_page: assert property (p_tbl_page)
		else $error("table page not from next address");
	property p_tbl_done;
		acc && tbl_now |-> ##3 exec_done;
	endproperty
	a_tbl_done: assert property (p_tbl_done)
		else $error("table read completion late");
	property p_rom_src;
		rom_rd |-> op_q <= OP_TBL_BCXA;
	endproperty
	a_rom_src: assert property (p_rom_src)
		else $error("ROM strobe outside table read");
	property p_carry_kept;
		acc && s_now |=> $stable(carry_flag)[*3];
	endproperty
	a_carry_kept: assert property (p_carry_kept)
		else $error("skip form changed carry");
	property p_skip_src;
		skip_req |-> s_q;
	endproperty
	a_skip_src: assert property (p_skip_src)
		else $error("skip from a non-skip form");
	property p_skip_done;
		skip_req |-> exec_done;
	endproperty
	a_skip_done: assert property (p_skip_done)
		else $error("skip without completion");
	property p_done_pulse;
		exec_done |=> !exec_done;
	endproperty
	a_done_pulse: assert property (p_done_pulse)
		else $error("completion longer than one cycle");
	property p_store;
		acc && exec_op == OP_BIT_STORE |=> dmem_rd ##2 dmem_wr ##1 exec_done;
	endproperty
	a_store: assert property (p_store)
		else $error("bit store sequence wrong");
	property p_wr_src;
		dmem_wr |-> op_q == OP_BIT_STORE;
	endproperty
	a_wr_src: assert property (p_wr_src)
		else $error("memory write outside bit store");
	c_tbl: cover property (acc && tbl_now);
	c_skip: cover property (skip_req);
	c_store: cover property (dmem_wr);
endmodule : tbl_alu_props

bind table_read_bit_move_add_sub_unit tbl_alu_props tbl_alu_props_inst (
	.sys_clk, .rst_n, .exec_valid, .exec_ready, .exec_op,
	.exec_prog_counter, .exec_done, .skip_req, .rom_rd, .rom_addr,
	.dmem_rd, .dmem_wr, .carry_flag
);

// >>> verification/table_read_bit_move_add_sub_unit_tb.sv
// Self-checking bench for the table read, bit move and add/sub datapath
module table_read_bit_move_add_sub_unit_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import tbl_alu_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic exec_valid = 1'b0;
	logic other_instr = 1'b0;
	op_t exec_op = OP_TBL_PCDE;
	bit_mode_t exec_bit_mode = BIT_FMEM;
	logic [7:0] exec_imm = 8'h00;
	logic [2:0] exec_pair = 3'h0;
	logic [1:0] exec_bit_sel = 2'h0;
	logic [10:0] exec_prog_counter = 11'h000;
	logic exec_ready, exec_done, skip_req, rom_rd, dmem_rd, dmem_wr;
	logic carry_flag, skip_seen;
	logic [10:0] rom_addr;
	logic [7:0] rom_rdata, wide_acc;
	logic [11:0] dmem_addr;
	logic [3:0] dmem_wdata, dmem_rdata;
	int n_fail = 0;
	int compares = 0;
	always #2 sys_clk = ~sys_clk;
	table_read_bit_move_add_sub_unit table_read_bit_move_add_sub_unit_inst (
		.sys_clk, .rst_n, .exec_valid, .exec_ready, .exec_op, .exec_imm,
		.exec_pair, .exec_bit_mode, .exec_bit_sel, .exec_prog_counter,
		.other_instr, .exec_done, .skip_req, .rom_rd, .rom_addr, .rom_rdata,
		.dmem_rd, .dmem_wr, .dmem_addr, .dmem_wdata, .dmem_rdata,
		.carry_flag, .wide_acc
	);
	mem_model mem_model_inst (
		.sys_clk, .rom_rd, .rom_addr, .rom_rdata, .dmem_rd, .dmem_wr,
		.dmem_addr, .dmem_wdata, .dmem_rdata
	);
	// -----
	// Shared drivers and comparison
	// -----
	task automatic chk(logic [11:0] seen, logic [11:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic run(op_t op, logic [7:0] imm = 8'h00, logic [2:0] pr = 3'h0,
		bit_mode_t md = BIT_FMEM, logic [1:0] sel = 2'h0,
		logic [10:0] pca = 11'h000);
		int n;
		@(posedge sys_clk);
		exec_valid <= 1'b1;
		exec_op <= op;
		exec_imm <= imm;
		exec_pair <= pr;
		exec_bit_mode <= md;
		exec_bit_sel <= sel;
		exec_prog_counter <= pca;
		@(posedge sys_clk);
		exec_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (exec_done !== 1'b1 && n < 8);
		chk(exec_done, 1'b1);
		chk(exec_ready, 1'b1);
		skip_seen = skip_req;
	endtask : run
	task automatic ar(op_t op, logic [7:0] wa, logic cy, logic sk,
		logic [2:0] pr = 3'h0, logic [7:0] imm = 8'h00);
		run(op, imm, pr);
		chk(wide_acc, wa);
		chk(carry_flag, cy);
		chk(skip_seen, sk);
	endtask : ar
	task automatic tr(op_t op, logic [10:0] pca, logic [10:0] a);
		run(op, 8'h00, 3'h0, BIT_FMEM, 2'h0, pca);
		chk(rom_addr, a);
		chk(wide_acc, mem_model_inst.rom_b(a));
	endtask : tr
	task automatic set_wa(logic [7:0] v);
		run(OP_SUBSK_W_RP);
		run(OP_ADDS_W_IMM, v);
	endtask : set_wa
	task automatic ldp(logic [2:0] pr, logic [7:0] v);
		set_wa(v);
		run(OP_ADDS_RP_W, 8'h00, pr);
	endtask : ldp
	task automatic final_report;
		if (n_fail == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : final_report
	// -----
	// Scenarios
	// -----
	task automatic t_tables;
		ldp(3'h2, 8'h5a);
		ldp(3'h1, 8'h3c);
		ldp(3'h3, 8'h05); // Top pointer nibble kept at zero
		tr(OP_TBL_PCDE, 11'h123, 11'h15a);
		tr(OP_TBL_PCDE, 11'h2ff, 11'h35a);
		tr(OP_TBL_PCXA, 11'h410, {3'h4, mem_model_inst.rom_b(11'h35a)});
		tr(OP_TBL_BCDE, 11'h7ff, 11'h55a);
		tr(OP_TBL_BCXA, 11'h000, {3'h5, mem_model_inst.rom_b(11'h55a)});
	endtask : t_tables
	task automatic t_bits;
		mem_model_inst.dmem[12'hff3] = 4'h4;
		mem_model_inst.dmem[12'hfb5] = 4'h7;
		mem_model_inst.dmem[12'h037] = 4'h0;
		mem_model_inst.dmem[12'hfcb] = 4'hf;
		run(OP_BIT_LOAD, 8'h13, 3'h0, BIT_FMEM, 2'h2);
		chk(carry_flag, 1'b1);
		run(OP_BIT_STORE, 8'h07, 3'h0, BIT_H_MEM, 2'h1);
		chk(mem_model_inst.dmem[12'h037], 4'h2);
		run(OP_BIT_LOAD, 8'h05, 3'h0, BIT_FMEM, 2'h3);
		chk(carry_flag, 1'b0);
		run(OP_BIT_STORE, 8'h02, 3'h0, BIT_PMEM_L, 2'h0);
		chk(mem_model_inst.dmem[12'hfcb], 4'he);
		run(OP_BIT_LOAD, 8'h07, 3'h0, BIT_H_MEM, 2'h1);
		chk(carry_flag, 1'b1);
	endtask : t_bits
	task automatic t_adds;
		set_wa(8'h0c);
		ar(OP_ADDS_A_IMM, 8'h01, 1'b1, 1'b1, 3'h0, 8'h05);
		ar(OP_ADDS_A_IMM, 8'h03, 1'b1, 1'b0, 3'h0, 8'h02);
		set_wa(8'hf0);
		ar(OP_ADDS_W_IMM, 8'h10, 1'b1, 1'b1, 3'h0, 8'h20);
		mem_model_inst.dmem[12'h03c] = 4'h9;
		ar(OP_ADDS_A_MEM, 8'h19, 1'b1, 1'b0);
		ar(OP_ADDS_A_MEM, 8'h12, 1'b1, 1'b1);
		ar(OP_ADDS_W_RP, 8'h6c, 1'b1, 1'b0, 3'h2);
		ar(OP_ADDS_RP_W, 8'h6c, 1'b1, 1'b0, 3'h0);
		ar(OP_ADDS_RP_W, 8'h6c, 1'b1, 1'b0, 3'h6);
		ar(OP_ADDS_W_RP, 8'hd8, 1'b1, 1'b0, 3'h6);
	endtask : t_adds
	task automatic t_carry;
		ar(OP_ADDCY_A_MEM, 8'hd2, 1'b1, 1'b0);
		ar(OP_ADDS_A_IMM, 8'hd2, 1'b1, 1'b0, 3'h0, 8'h06);
		ar(OP_ADDCY_A_MEM, 8'hdc, 1'b0, 1'b0);
		ar(OP_ADDS_A_IMM, 8'hd2, 1'b0, 1'b0, 3'h0, 8'h06);
		ar(OP_ADDCY_W_RP, 8'h2c, 1'b1, 1'b0, 3'h2);
		ar(OP_ADDCY_RP_W, 8'h2c, 1'b0, 1'b0, 3'h2);
	endtask : t_carry
	task automatic t_sub_skip_on_borrow;
		ar(OP_SUBSK_W_RP, 8'ha5, 1'b0, 1'b1, 3'h2);
		ar(OP_SUBSK_A_MEM, 8'hac, 1'b0, 1'b1);
		ar(OP_SUBSK_RP_W, 8'hac, 1'b0, 1'b1, 3'h2);
		ar(OP_SUBSK_W_RP, 8'hd1, 1'b0, 1'b1, 3'h2);
		ar(OP_SUBCY_A_MEM, 8'hd8, 1'b1, 1'b0);
		mem_model_inst.dmem[12'h03c] = 4'h2;
		ar(OP_SUBCY_A_MEM, 8'hd5, 1'b0, 1'b0);
		@(posedge sys_clk);
		other_instr <= 1'b1;
		@(posedge sys_clk);
		other_instr <= 1'b0;
		ar(OP_ADDS_A_IMM, 8'hd2, 1'b0, 1'b1, 3'h0, 8'h0d);
		ar(OP_SUBCY_W_RP, 8'hf7, 1'b1, 1'b0, 3'h2);
		ar(OP_SUBCY_RP_W, 8'hf7, 1'b1, 1'b0, 3'h2);
	endtask : t_sub_skip_on_borrow
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_fail++;
		final_report();
	end
	initial begin
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_tables();
		t_bits();
		t_adds();
		t_carry();
		t_sub_skip_on_borrow();
		final_report();
	end
endmodule : table_read_bit_move_add_sub_unit_tb
